/* File: dv/test_uart_with_timer2_baud.sv */
`default_nettype none
module test_uart_with_timer2_baud;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h00000000;
   logic we = 1'b0;
   logic stb = 1'b0;
   logic cyc = 1'b0;
   logic trig = 1'b1;
   logic t1ov = 1'b0;
   wire [31:0] rdat;
   wire [7:0] got;
   wire ack, rxd_o, oe_n, txd_o, sirq, tirq, line, stp;
   int err_total = 0;
   int n_checks = 0;
   int cyc_n = 0;

   always #5 clk_i = ~clk_i;

   // pin level: design drives only while its enable is low
   uwt_top uwt_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(oe_n ? line : rxd_o), .rxd_o(rxd_o),
      .rxd_oe_n_o(oe_n), .txd_o(txd_o), .ext_trigger_pin_i(trig), .t1_overflow_i(t1ov),
      .serial_irq_o(sirq), .timer_two_irq_o(tirq));
   uwt_remote #(.BIT(32)) uwt_remote_i (.clk_i(clk_i), .txd_i(txd_o), .line_o(line),
      .got_o(got), .stop_o(stp));

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // hang guard, well above the longest sequence
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         err_total++;
      end
   endtask

   // classic cycle, held until ack is sampled high
   task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
         output logic [7:0] q);
      adr <= a;
      we <= w;
      wdat <= {24'h000000, d};
      stb <= 1'b1;
      cyc <= 1'b1;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat[7:0];
      stb <= 1'b0;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(a, 1'b0, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask

   task automatic wait_hi(input logic s);
      for (int i = 0; i < 3000; i++) begin
         if ((s ? sirq : tirq) === 1'b1) break;
         @(posedge clk_i);
      end
   endtask

   task automatic pulse_trig();
      trig <= 1'b0;
      repeat (3) @(posedge clk_i);
      trig <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic t_regs();
      rd(5'h00, 8'h00);
      rd(5'h08, 8'h00);
      wr(5'h02, 8'hFF);
      rd(5'h02, 8'h00);
      rd(5'h00, 8'h00);
   endtask

   task automatic t_timer();
      wr(5'h0C, 8'hF0);
      wr(5'h10, 8'hFF);
      wr(5'h14, 8'hF0);
      wr(5'h18, 8'hFF);
      wr(5'h08, 8'h04);
      wait_hi(1'b0);
      rd(5'h08, 8'h84);
      rd(5'h18, 8'hFF);
      wr(5'h08, 8'h08);
      wr(5'h14, 8'h00);
      pulse_trig();
      rd(5'h14, 8'hF0);
      rd(5'h08, 8'h48);
      wr(5'h08, 8'h09);
      wr(5'h14, 8'h34);
      wr(5'h18, 8'h12);
      pulse_trig();
      rd(5'h0C, 8'h34);
      rd(5'h10, 8'h12);
      rd(5'h08, 8'h49);
      wr(5'h14, 8'hFF);
      wr(5'h18, 8'hFF);
      wr(5'h08, 8'h05);
      wait_hi(1'b0);
      rd(5'h08, 8'h85);
      rd(5'h18, 8'h00);
      wr(5'h08, 8'h00);
   endtask

   // reload FFFE gives a 32-clock bit in both directions
   task automatic t_tx();
      wr(5'h0C, 8'hFE);
      wr(5'h10, 8'hFF);
      wr(5'h14, 8'hFE);
      wr(5'h18, 8'hFF);
      wr(5'h00, 8'h40);
      wr(5'h08, 8'h34);
      wr(5'h04, 8'hA5);
      wait_hi(1'b1);
      chk("txd at done", 8'h01, {7'h00, txd_o});
      repeat (32) @(posedge clk_i);
      chk("tx byte", 8'hA5, got);
      chk("tx stop", 8'h01, {7'h00, stp});
      rd(5'h00, 8'h42);
      rd(5'h08, 8'h34);
      wr(5'h00, 8'h40);
   endtask

   task automatic t_rx();
      wr(5'h00, 8'h50);
      uwt_remote_i.send(8'h3C, 1'b1);
      wait_hi(1'b1);
      rd(5'h04, 8'h3C);
      rd(5'h00, 8'h55);
      uwt_remote_i.send(8'hC3, 1'b1);
      rd(5'h04, 8'h3C);
      wr(5'h00, 8'h50);
      uwt_remote_i.send(8'h81, 1'b0);
      rd(5'h04, 8'h3C);
      rd(5'h00, 8'h50);
   endtask

   // timer-one pulse every clock, halved, gives the same 32-clock bit
   task automatic t_t1();
      wr(5'h08, 8'h00);
      wr(5'h00, 8'h40);
      t1ov <= 1'b1;
      wr(5'h04, 8'h5A);
      wait_hi(1'b1);
      repeat (32) @(posedge clk_i);
      chk("t1 tx byte", 8'h5A, got);
      t1ov <= 1'b0;
      wr(5'h00, 8'h40);
   endtask

   task automatic t_shift();
      logic [7:0] b;
      wr(5'h00, 8'h00);
      wr(5'h04, 8'h96);
      for (int i = 0; i < 8; i++) begin
         @(posedge txd_o);
         b[i] = rxd_o;
      end
      chk("shift out", 8'h96, b);
      wait_hi(1'b1);
      rd(5'h00, 8'h02);
      wr(5'h00, 8'h10);
      uwt_remote_i.feed(8'h5A);
      wait_hi(1'b1);
      rd(5'h04, 8'h5A);
      rd(5'h00, 8'h11);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_timer();
      t_tx();
      t_rx();
      t_t1();
      t_shift();
      report_and_stop();
   end
endmodule

bind uwt_top uwt_props uwt_props_i (.clk_i, .rst_i, .ce_i, .wb_we_i, .wb_stb_i, .wb_cyc_i,
   .wb_dat_o, .wb_ack_o, .rxd_o, .rxd_oe_n_o, .txd_o, .serial_irq_o, .timer_two_irq_o);
`default_nettype wire

/* File: dv/uwt_props.sv */
`default_nettype none
// port-level checks on the bus handshake, shift clock and flag lifetimes
module uwt_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_we_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rxd_o,
   input wire logic rxd_oe_n_o,
   input wire logic txd_o,
   input wire logic serial_irq_o,
   input wire logic timer_two_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // bus answers on the very next edge, for one cycle only
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved without ack");
   a_rst_idle: assert property ($fell(rst_i) |-> txd_o && rxd_oe_n_o && !wb_ack_o
         && !serial_irq_o && !timer_two_irq_o)
      else $error("outputs not idle after reset");
   // shift clock low half is six core clocks
   a_shift_low: assert property ($fell(txd_o) && !rxd_oe_n_o |-> !txd_o [*6] ##1 txd_o)
      else $error("shift clock low phase wrong");
   a_shift_hold: assert property (!rxd_oe_n_o && $rose(txd_o) |-> $stable(rxd_o))
      else $error("shift data moved at clock rise");
   // flags only drop after a software write
   a_tirq_clear: assert property ($fell(timer_two_irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("timer flag dropped without write");
   a_sirq_clear: assert property ($fell(serial_irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("serial flag dropped without write");
endmodule
`default_nettype wire

/* File: dv/uwt_remote.sv */
`default_nettype none
// remote serial device on the receive and transmit pins
module uwt_remote #(
   parameter int BIT = 32
) (
   input wire logic clk_i,
   input wire logic txd_i,
   output var logic line_o,
   output var logic [7:0] got_o,
   output var logic stop_o
);
   initial line_o = 1'b1;

   // one frame: start 0, data lsb first, stop bit as given
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      f = {stp, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_o <= f[i];
         repeat (BIT) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask

   // shift-mode source: each bit placed on the data line at the clock fall
   task automatic feed(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge txd_i);
         line_o <= b[i];
      end
      @(posedge txd_i);
      line_o <= 1'b1;
   endtask

   // listener samples mid-bit, so a wrong rate garbles the byte
   always begin
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         repeat (BIT) @(posedge clk_i);
         got_o[k] = txd_i;
      end
      repeat (BIT) @(posedge clk_i);
      stop_o = txd_i;
   end
endmodule
`default_nettype wire

/* File: verilog/uwt_consts.vh */
`ifndef UWT_CONSTS_VH
`define UWT_CONSTS_VH
// register byte offsets
`define UWT_OFF_SCTL 5'h00
`define UWT_OFF_SERIAL_BUFFER 5'h04
`define UWT_OFF_T2CTL 5'h08
`define UWT_OFF_RLDL 5'h0C
`define UWT_OFF_RLDH 5'h10
`define UWT_OFF_CNTL 5'h14
`define UWT_OFF_CNTH 5'h18
`define UWT_OFF_AUX 5'h1C
// serial_control fields
`define UWT_SC_TI 1
`define UWT_SC_RI 0
`define UWT_SC_RB8 2
`define UWT_SC_REN 4
`define UWT_SC_SM2 5
`define UWT_SC_SM1 6
`define UWT_SC_SM0 7
// timer_two_control fields
`define UWT_T2_CAP 0
`define UWT_T2_RUN 2
`define UWT_T2_EXEN 3
`define UWT_T2_TX_BAUD_FROM_TIMER_TWO 4
`define UWT_T2_RCLK 5
`define UWT_T2_EXF 6
`define UWT_T2_TF 7
// aux register field
`define UWT_AUX_DBL 0
// reset value of every byte register
`define UWT_RST_BYTE 8'h00
// timing counts: core clocks for the first three, oversample ticks for the last two
`define UWT_M0_DIV 12
`define UWT_M0_HALF 6
`define UWT_T2_PRE 12
`define UWT_OVS 16
`define UWT_MID 8
`endif

/* File: verilog/uwt_top.v */
// The address map and the Wishbone slave port were left to the implementer.
`include "uwt_consts.vh"
`default_nettype none
module uwt_top (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [4:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_stb_i,
   input wire wb_cyc_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire rxd_i,
   output wire rxd_o,
   output wire rxd_oe_n_o,
   output wire txd_o,
   input wire ext_trigger_pin_i,
   input wire t1_overflow_i,
   output wire serial_irq_o,
   output wire timer_two_irq_o
);

   // address match, used by the write decode only; reads decode with a case on the address
   function hit;
      input [4:0] a;
      input [4:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   reg ack_q;
   reg [7:0] dat_q;
   reg [7:0] sctl_q;
   reg [7:0] t2ctl_q;
   reg [7:0] rld_lo_q;
   reg [7:0] rld_hi_q;
   reg [15:0] cnt_q;
   reg dbl_q;
   reg [7:0] rbuf_q;
   reg [3:0] pre_q;
   reg trig_prev_q;
   reg rxd_prev_q;
   reg t1_half_q;
   reg [3:0] tx_div_q;
   reg [3:0] tx_bit_q;
   reg [8:0] tx_sh_q;
   reg tx_pend_q;
   reg tx_line_q;
   reg rx_busy_q;
   reg [3:0] rx_ph_q;
   reg [3:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg m0_busy_q;
   reg m0_rx_q;
   reg [3:0] m0_ph_q;
   reg [2:0] m0_bit_q;
   reg [7:0] m0_sh_q;
   reg m0_clk_q;
   reg m0_dat_q;
   reg txd_q;

   // bus strobes; writes land on the edge that sees ack high
   wire req = wb_cyc_i & wb_stb_i;
   wire wr = req & ack_q & wb_we_i & wb_sel_i[0];
   wire wr_sctl = wr & hit(wb_adr_i, `UWT_OFF_SCTL);
   wire wr_serial_buffer = wr & hit(wb_adr_i, `UWT_OFF_SERIAL_BUFFER);
   wire wr_t2 = wr & hit(wb_adr_i, `UWT_OFF_T2CTL);
   wire wr_cntl = wr & hit(wb_adr_i, `UWT_OFF_CNTL);
   wire wr_cnth = wr & hit(wb_adr_i, `UWT_OFF_CNTH);
   wire [7:0] wd = wb_dat_i[7:0];

   // mode decode
   wire mode0 = ~sctl_q[`UWT_SC_SM0] & ~sctl_q[`UWT_SC_SM1];
   wire mode1 = ~sctl_q[`UWT_SC_SM0] & sctl_q[`UWT_SC_SM1];
   wire ren = sctl_q[`UWT_SC_REN];
   wire ri = sctl_q[`UWT_SC_RI];
   wire tx_baud_from_timer_two = t2ctl_q[`UWT_T2_TX_BAUD_FROM_TIMER_TWO];
   wire rclk = t2ctl_q[`UWT_T2_RCLK];
   wire run = t2ctl_q[`UWT_T2_RUN];
   wire baud = tx_baud_from_timer_two | rclk;
   wire cap = t2ctl_q[`UWT_T2_CAP] & ~baud;
   wire exen = t2ctl_q[`UWT_T2_EXEN];
   wire [15:0] rld = {rld_hi_q, rld_lo_q};

   // timer two: one count per clock as baud source, per 12 clocks otherwise
   // the shortest baud reload (FFFF) gives one tick per clock; faster is impossible
   wire pre_end = (pre_q == `UWT_T2_PRE - 1);
   wire t2_inc = run & (baud | pre_end);
   wire t2_ovf = t2_inc & (cnt_q == 16'hFFFF);
   wire trig_fall = trig_prev_q & ~ext_trigger_pin_i & exen;
   wire t2_baud_tick = t2_ovf & baud;

   // oversample ticks (16 per bit) per direction
   // timer one pulses are halved unless doubled; the halver is shared by both
   // directions, so each sees the same tick train
   wire t1_tick = t1_overflow_i & (dbl_q | t1_half_q);
   wire tx_tick = tx_baud_from_timer_two ? t2_baud_tick : t1_tick;
   wire rx_tick = rclk ? t2_baud_tick : t1_tick;
   wire tx_bit_tick = tx_tick & (tx_div_q == `UWT_OVS - 1);
   wire rx_fall = rxd_prev_q & ~rxd_i;
   wire rx_mid = rx_tick & (rx_ph_q == `UWT_MID - 1);

   // event pulses for the done flags and the shift-mode start
   wire m0_last = m0_busy_q & (m0_ph_q == `UWT_M0_DIV - 1) & (m0_bit_q == 3'd7);
   wire m0_ri_set = m0_last & m0_rx_q;
   wire m0_ti_set = m0_last & ~m0_rx_q;
   wire u_ti_set = mode1 & tx_bit_tick & (tx_bit_q == 4'd9);
   wire rx_stop = rx_busy_q & rx_mid & (rx_bit_q == 4'd9);
   wire rx_take = rx_stop & ~ri & rxd_i;
   wire m0_start_tx = mode0 & wr_serial_buffer & ~m0_busy_q;
   wire m0_start_rx = mode0 & ren & ~ri & ~m0_busy_q & ~wr_serial_buffer;

   // wishbone slave: ack one cycle after request, read data from flip-flops
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= `UWT_RST_BYTE;
      end else if (ce_i) begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            case (wb_adr_i)
               `UWT_OFF_SCTL: dat_q <= sctl_q;
               `UWT_OFF_SERIAL_BUFFER: dat_q <= rbuf_q;
               `UWT_OFF_T2CTL: dat_q <= t2ctl_q;
               `UWT_OFF_RLDL: dat_q <= rld_lo_q;
               `UWT_OFF_RLDH: dat_q <= rld_hi_q;
               `UWT_OFF_CNTL: dat_q <= cnt_q[7:0];
               `UWT_OFF_CNTH: dat_q <= cnt_q[15:8];
               `UWT_OFF_AUX: dat_q <= {7'h00, dbl_q};
               default: dat_q <= 8'h00; // unmapped reads as zero
            endcase
         end
      end
   end

   // serial control; hardware set beats a software clear in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         sctl_q <= `UWT_RST_BYTE;
      end else if (ce_i) begin
         if (wr_sctl)
            sctl_q <= wd;
         if (m0_ti_set | u_ti_set)
            sctl_q[`UWT_SC_TI] <= 1'b1;
         if (m0_ri_set | rx_take)
            sctl_q[`UWT_SC_RI] <= 1'b1;
         if (rx_take)
            sctl_q[`UWT_SC_RB8] <= rxd_i;
      end
   end

   // timer two control, reload bytes and aux
   always @(posedge clk_i) begin
      if (rst_i) begin
         t2ctl_q <= `UWT_RST_BYTE;
         rld_lo_q <= `UWT_RST_BYTE;
         rld_hi_q <= `UWT_RST_BYTE;
         dbl_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_t2)
            t2ctl_q <= wd;
         if (wr & hit(wb_adr_i, `UWT_OFF_RLDL))
            rld_lo_q <= wd;
         if (wr & hit(wb_adr_i, `UWT_OFF_RLDH))
            rld_hi_q <= wd;
         if (wr & hit(wb_adr_i, `UWT_OFF_AUX))
            dbl_q <= wd[`UWT_AUX_DBL];
         if (t2_ovf & ~baud)
            t2ctl_q[`UWT_T2_TF] <= 1'b1;
         if (trig_fall)
            t2ctl_q[`UWT_T2_EXF] <= 1'b1;
         if (trig_fall & cap) begin
            rld_lo_q <= cnt_q[7:0];
            rld_hi_q <= cnt_q[15:8];
         end
      end
   end

   // timer two count; software writes win over counting
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 16'h0000;
         pre_q <= 4'h0;
         trig_prev_q <= 1'b1;
      end else if (ce_i) begin
         trig_prev_q <= ext_trigger_pin_i;
         pre_q <= (pre_end | ~run) ? 4'h0 : pre_q + 4'h1;
         if (wr_cntl)
            cnt_q[7:0] <= wd;
         else if (wr_cnth)
            cnt_q[15:8] <= wd;
         else if (trig_fall & ~cap & ~baud)
            cnt_q <= rld;
         else if (t2_ovf)
            cnt_q <= cap ? 16'h0000 : rld;
         else if (t2_inc)
            cnt_q <= cnt_q + 16'h0001;
      end
   end

   // uart transmitter: start, eight data, stop from the ninth shifter bit
   // the bit divider runs free, so a frame starts up to one bit time after the write
   // a write during a running frame is dropped rather than queued
   always @(posedge clk_i) begin
      if (rst_i) begin
         t1_half_q <= 1'b0;
         tx_div_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 9'h1FF;
         tx_pend_q <= 1'b0;
         tx_line_q <= 1'b1;
      end else if (ce_i) begin
         if (t1_overflow_i)
            t1_half_q <= ~t1_half_q;
         if (tx_tick)
            tx_div_q <= tx_div_q + 4'h1;
         if (mode1 & wr_serial_buffer & ~tx_pend_q & (tx_bit_q == 4'd0)) begin
            tx_sh_q <= {1'b1, wd};
            tx_pend_q <= 1'b1;
         end else if (tx_bit_tick) begin
            if (tx_bit_q == 4'd0) begin
               if (tx_pend_q) begin
                  tx_line_q <= 1'b0;
                  tx_pend_q <= 1'b0;
                  tx_bit_q <= 4'd1;
               end
            end else if (tx_bit_q == 4'd10) begin
               tx_bit_q <= 4'd0;
            end else begin
               tx_line_q <= tx_sh_q[0];
               tx_sh_q <= {1'b1, tx_sh_q[8:1]};
               tx_bit_q <= tx_bit_q + 4'd1;
            end
         end
      end
   end

   // uart receiver: phase counter restarts on the start edge
   // no glitch filter on the pin: the mid-bit recheck of the start bit is the only
   // guard against a short low pulse
   always @(posedge clk_i) begin
      if (rst_i) begin
         rxd_prev_q <= 1'b1;
         rx_busy_q <= 1'b0;
         rx_ph_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
      end else if (ce_i) begin
         rxd_prev_q <= rxd_i;
         if (~rx_busy_q) begin
            if (mode1 & ren & rx_fall) begin
               rx_busy_q <= 1'b1;
               rx_ph_q <= 4'h0;
               rx_bit_q <= 4'h0;
            end
         end else if (rx_tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_mid) begin
               if (rx_bit_q == 4'd0 && rxd_i)
                  rx_busy_q <= 1'b0;
               else if (rx_bit_q == 4'd9)
                  rx_busy_q <= 1'b0;
               else begin
                  if (rx_bit_q != 4'd0)
                     rx_sh_q <= {rxd_i, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 4'd1;
               end
            end
         end
      end
   end

   // receive buffer, loaded by either engine
   // the shift-mode byte is complete at its last clock rise, so it is taken
   // as it stands; one more shift here would lose the first bit received
   always @(posedge clk_i) begin
      if (rst_i)
         rbuf_q <= `UWT_RST_BYTE;
      else if (ce_i) begin
         if (rx_take)
            rbuf_q <= rx_sh_q;
         else if (m0_ri_set)
            rbuf_q <= m0_sh_q;
      end
   end

   // shift-register mode: clock low for 6, high for 6 core clocks
   // data changes at the clock fall and is sampled at the rise, half a bit apart
   always @(posedge clk_i) begin
      if (rst_i) begin
         m0_busy_q <= 1'b0;
         m0_rx_q <= 1'b0;
         m0_ph_q <= 4'h0;
         m0_bit_q <= 3'd0;
         m0_sh_q <= 8'h00;
         m0_clk_q <= 1'b1;
         m0_dat_q <= 1'b1;
      end else if (ce_i) begin
         if (m0_start_tx | m0_start_rx) begin
            m0_busy_q <= 1'b1;
            m0_rx_q <= m0_start_rx;
            m0_ph_q <= 4'h0;
            m0_bit_q <= 3'd0;
            m0_sh_q <= m0_start_tx ? wd : 8'h00;
         end else if (m0_busy_q) begin
            if (m0_ph_q == 4'h0) begin
               m0_clk_q <= 1'b0;
               m0_dat_q <= m0_sh_q[0];
            end
            if (m0_ph_q == `UWT_M0_HALF) begin
               m0_clk_q <= 1'b1;
               m0_sh_q <= {m0_rx_q & rxd_i, m0_sh_q[7:1]};
            end
            if (m0_ph_q == `UWT_M0_DIV - 1) begin
               m0_ph_q <= 4'h0;
               m0_bit_q <= m0_bit_q + 3'd1;
               if (m0_last)
                  m0_busy_q <= 1'b0;
            end else
               m0_ph_q <= m0_ph_q + 4'h1;
         end
      end
   end

   // transmit pin carries the shift clock in mode 0, the line in mode 1
   always @(posedge clk_i) begin
      if (rst_i)
         txd_q <= 1'b1;
      else if (ce_i)
         txd_q <= mode0 ? m0_clk_q : tx_line_q;
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = {24'h000000, dat_q};
   // receive pin driven only while shifting data out
   assign rxd_o = m0_dat_q;
   assign rxd_oe_n_o = ~(m0_busy_q & ~m0_rx_q);
   assign txd_o = txd_q;
   assign serial_irq_o = sctl_q[`UWT_SC_TI] | sctl_q[`UWT_SC_RI];
   assign timer_two_irq_o = t2ctl_q[`UWT_T2_TF] | t2ctl_q[`UWT_T2_EXF];

endmodule
`default_nettype wire
